// [hw/sefc_supervisor.sv]
`timescale 1ns/100ps
// Overview of operation
// - Enable raises ready flag together with serial acknowledge
// - Enable starts always-on and asserted-GPIO channels
// - Enable pin high enables, low disables chip
// - Serial soft reset performs full chip reset
// - Channel enable by default, GPIO or serial
// - Standby level 3.3V/5V; selectable on/off source
// - Built-in non-overlap off when programmable dead time
// - Control bit selects programmable versus fixed dead time
// - Rising and falling gaps follow their settings
// - Dead-time step equals switching period over 256
// - Input undervoltage fault flags and stops all
// - Output over-voltage stops that channel
// - Over-current stops channel, restarts after 200ms
// - Undervoltage warning level sets readable warning flag
// - Undervoltage fault level reported in status
// - Input voltages readable at 100mV per step
// - Rising above warning level restarts if configured
// - Temperature readable in 5K steps, 200K-520K
// - Over-temperature warning 5 or 10 below fault
// - Critical temperature stops all channels
// - Over-temperature sets both bits, serial stays up
// - Power-up copies stored configuration into registers
module sefc_supervisor
    import sefc_pkg::*;
#(
    parameter longint OC_WAIT_CYCLES = SEFC_OC_WAIT_CYCLES
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic clk_en,
    input wire logic chip_enable_pin,
    input wire logic [5:0] gpio_pin,
    input wire logic soft_reset_command,
    input wire logic ser_cfg_write,
    input wire logic flag_clear,
    input wire logic [3:0] serial_channel_enable,
    input wire logic [7:0] store_enable_mode,
    input wire logic [11:0] store_gpio_select,
    input wire logic [2:0] store_standby_regulator_config,
    input wire logic store_prog_dead_time_en,
    input wire logic [31:0] store_rising_dead_time_setting,
    input wire logic [31:0] store_falling_dead_time_setting,
    input wire logic [15:0] store_input_undervolt_warning_level,
    input wire logic [15:0] store_input_undervolt_fault_level,
    input wire logic [6:0] store_thermal_shutdown_level,
    input wire logic [6:0] store_thermal_restart_level,
    input wire logic store_otw_far,
    input wire logic [1:0] store_auto_restart,
    input wire logic [7:0] ser_enable_mode,
    input wire logic [11:0] ser_gpio_select,
    input wire logic [2:0] ser_standby_regulator_config,
    input wire logic ser_prog_dead_time_en,
    input wire logic [31:0] ser_rising_dead_time_setting,
    input wire logic [31:0] ser_falling_dead_time_setting,
    input wire logic [15:0] ser_input_undervolt_warning_level,
    input wire logic [15:0] ser_input_undervolt_fault_level,
    input wire logic [6:0] ser_thermal_shutdown_level,
    input wire logic [6:0] ser_thermal_restart_level,
    input wire logic ser_otw_far,
    input wire logic [1:0] ser_auto_restart,
    input wire logic [7:0] primary_input_supply_code,
    input wire logic [7:0] secondary_input_supply_code,
    input wire logic [6:0] temperature_code,
    input wire logic [3:0] ov_trip,
    input wire logic [3:0] oc_trip,
    input wire logic [3:0] pwm_demand,
    input wire logic [15:0] switch_period_cycles,
    output logic chip_ready,
    output logic serial_ack_allow,
    output logic [3:0] channel_run,
    output logic [3:0] gate_high,
    output logic [3:0] gate_low,
    output logic driver_overlap_guard_en,
    output logic standby_regulator_on,
    output logic standby_level_5v,
    output logic [7:0] protection_status_flags,
    output logic [1:0] uv_warning_flags,
    output logic [3:0] ocp_fault_flags,
    output logic uv_warning_gpio,
    output logic [7:0] input1_voltage_readback,
    output logic [7:0] input2_voltage_readback,
    output logic [6:0] junction_temperature_readback
);

    ////////////////////////////////////////////////////////////////////////
    // Functions

    function automatic logic [15:0] sefc_dead_cycles(input logic [7:0] setting, input logic [15:0] period);
        logic [23:0] prod;
        prod = 24'(setting) * 24'(period);
        sefc_dead_cycles = 16'(prod >> SEFC_DT_SHIFT);
    endfunction : sefc_dead_cycles

    function automatic logic [6:0] sefc_temp_clamp(input logic [6:0] code);
        if (code < SEFC_TEMP_MIN_CODE) begin
            sefc_temp_clamp = SEFC_TEMP_MIN_CODE;
        end else if (code > SEFC_TEMP_MAX_CODE) begin
            sefc_temp_clamp = SEFC_TEMP_MAX_CODE;
        end else begin
            sefc_temp_clamp = code;
        end
    endfunction : sefc_temp_clamp

    ////////////////////////////////////////////////////////////////////////
    // Input synchronisers

    logic enable_meta_reg;
    logic enable_sync_reg;
    logic [5:0] gpio_meta_reg;
    logic [5:0] gpio_sync_reg;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            enable_meta_reg <= 1'b0;
            enable_sync_reg <= 1'b0;
            gpio_meta_reg <= 6'h00;
            gpio_sync_reg <= 6'h00;
        end else if (clk_en) begin
            enable_meta_reg <= chip_enable_pin;
            enable_sync_reg <= enable_meta_reg;
            gpio_meta_reg <= gpio_pin;
            gpio_sync_reg <= gpio_meta_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Chip sequencing

    sefc_state_t state_reg;
    sefc_state_t state_next;

    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            SEFC_ST_LOAD: state_next = SEFC_ST_OFF;
            SEFC_ST_OFF: if (enable_sync_reg) state_next = SEFC_ST_READY;
            SEFC_ST_READY: if (!enable_sync_reg) state_next = SEFC_ST_OFF;
            default: state_next = SEFC_ST_LOAD;
        endcase
        if (soft_reset_command) begin
            state_next = SEFC_ST_LOAD;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_reg <= SEFC_ST_LOAD;
        end else if (clk_en) begin
            state_reg <= state_next;
        end
    end

    logic ready;
    assign ready = (state_reg == SEFC_ST_READY);
    assign chip_ready = ready;
    assign serial_ack_allow = ready;

    ////////////////////////////////////////////////////////////////////////
    // Configuration registers

    logic [7:0] mode_reg;
    logic [11:0] gsel_reg;
    logic [2:0] stby_reg;
    logic prog_dt_reg;
    logic [31:0] dt_rise_reg;
    logic [31:0] dt_fall_reg;
    logic [15:0] uv_warn_reg;
    logic [15:0] uv_fault_reg;
    logic [6:0] ot_shdn_reg;
    logic [6:0] ot_rst_reg;
    logic otw_far_reg;
    logic [1:0] auto_rst_reg;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            mode_reg <= 8'h00;
            gsel_reg <= 12'h000;
            stby_reg <= 3'h0;
            prog_dt_reg <= 1'b0;
            dt_rise_reg <= 32'h00000000;
            dt_fall_reg <= 32'h00000000;
            uv_warn_reg <= 16'h0000;
            uv_fault_reg <= 16'h0000;
            ot_shdn_reg <= 7'h7f;
            ot_rst_reg <= 7'h00;
            otw_far_reg <= 1'b0;
            auto_rst_reg <= 2'h0;
        end else if (clk_en) begin
            if (state_reg == SEFC_ST_LOAD) begin
                mode_reg <= store_enable_mode;
                gsel_reg <= store_gpio_select;
                stby_reg <= store_standby_regulator_config;
                prog_dt_reg <= store_prog_dead_time_en;
                dt_rise_reg <= store_rising_dead_time_setting;
                dt_fall_reg <= store_falling_dead_time_setting;
                uv_warn_reg <= store_input_undervolt_warning_level;
                uv_fault_reg <= store_input_undervolt_fault_level;
                ot_shdn_reg <= store_thermal_shutdown_level;
                ot_rst_reg <= store_thermal_restart_level;
                otw_far_reg <= store_otw_far;
                auto_rst_reg <= store_auto_restart;
            end else if (ser_cfg_write && ready) begin
                mode_reg <= ser_enable_mode;
                gsel_reg <= ser_gpio_select;
                stby_reg <= ser_standby_regulator_config;
                prog_dt_reg <= ser_prog_dead_time_en;
                dt_rise_reg <= ser_rising_dead_time_setting;
                dt_fall_reg <= ser_falling_dead_time_setting;
                uv_warn_reg <= ser_input_undervolt_warning_level;
                uv_fault_reg <= ser_input_undervolt_fault_level;
                ot_shdn_reg <= ser_thermal_shutdown_level;
                ot_rst_reg <= ser_thermal_restart_level;
                otw_far_reg <= ser_otw_far;
                auto_rst_reg <= ser_auto_restart;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Input supply and temperature monitoring

    logic [1:0] uv_fault_now;
    logic [1:0] uv_warn_now;
    logic [1:0] above_warn;
    logic ot_fault_now;
    logic otw_now;
    logic uv_active_reg;
    logic ot_active_reg;
    logic [7:0] otw_margin;

    assign uv_fault_now[0] = primary_input_supply_code < uv_fault_reg[7:0];
    assign uv_fault_now[1] = secondary_input_supply_code < uv_fault_reg[15:8];
    assign uv_warn_now[0] = primary_input_supply_code <= uv_warn_reg[7:0];
    assign uv_warn_now[1] = secondary_input_supply_code <= uv_warn_reg[15:8];
    assign above_warn = ~uv_warn_now;
    assign ot_fault_now = temperature_code >= ot_shdn_reg;
    assign otw_margin = otw_far_reg ? SEFC_OTW_MARGIN_FAR : SEFC_OTW_MARGIN_NEAR;
    assign otw_now = ({1'b0, temperature_code} + otw_margin) >= {1'b0, ot_shdn_reg};
    assign uv_warning_gpio = |uv_warn_now;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            uv_active_reg <= 1'b0;
        end else if (clk_en) begin
            if (!ready) begin
                uv_active_reg <= 1'b0;
            end else if (|uv_fault_now) begin
                uv_active_reg <= 1'b1;
            end else if ((&above_warn) && auto_rst_reg[SEFC_AR_UV_BIT]) begin
                uv_active_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ot_active_reg <= 1'b0;
        end else if (clk_en) begin
            if (!ready) begin
                ot_active_reg <= 1'b0;
            end else if (ot_fault_now) begin
                ot_active_reg <= 1'b1;
            end else if ((temperature_code <= ot_rst_reg) && auto_rst_reg[SEFC_AR_OT_BIT]) begin
                ot_active_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            input1_voltage_readback <= 8'h00;
            input2_voltage_readback <= 8'h00;
            junction_temperature_readback <= SEFC_TEMP_MIN_CODE;
        end else if (clk_en) begin
            input1_voltage_readback <= primary_input_supply_code;
            input2_voltage_readback <= secondary_input_supply_code;
            junction_temperature_readback <= sefc_temp_clamp(temperature_code);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Channel requests, over-voltage and over-current

    logic [3:0] request;
    logic [3:0] ov_latch_reg;
    logic [3:0] oc_wait_reg;
    logic [SEFC_OC_CNT_W-1:0] oc_cnt_reg [4];
    logic [3:0] run;

    always_comb begin
        for (int i = 0; i < 4; i++) begin
            unique case (mode_reg[2*i +: 2])
                SEFC_MODE_ALWAYS: request[i] = 1'b1;
                SEFC_MODE_GPIO: request[i] = gpio_sync_reg[gsel_reg[3*i +: 3]];
                SEFC_MODE_SERIAL: request[i] = serial_channel_enable[i];
                SEFC_MODE_OFF: request[i] = 1'b0;
            endcase
            request[i] = request[i] | serial_channel_enable[i];
        end
    end

    assign run = request & ~ov_latch_reg & ~oc_wait_reg & {4{ready && !uv_active_reg && !ot_active_reg}};
    assign channel_run = run;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ov_latch_reg <= SEFC_FLAGS_RST;
        end else if (clk_en) begin
            for (int i = 0; i < 4; i++) begin
                if (ov_trip[i] && run[i]) begin
                    ov_latch_reg[i] <= 1'b1;
                end else if (!request[i] || !ready) begin
                    ov_latch_reg[i] <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            oc_wait_reg <= SEFC_FLAGS_RST;
            for (int i = 0; i < 4; i++) begin
                oc_cnt_reg[i] <= '0;
            end
        end else if (clk_en) begin
            for (int i = 0; i < 4; i++) begin
                if (oc_trip[i] && run[i]) begin
                    oc_wait_reg[i] <= 1'b1;
                    oc_cnt_reg[i] <= SEFC_OC_CNT_W'(OC_WAIT_CYCLES - 1);
                end else if (!ready) begin
                    oc_wait_reg[i] <= 1'b0;
                end else if (oc_wait_reg[i]) begin
                    if (oc_cnt_reg[i] == '0) begin
                        oc_wait_reg[i] <= 1'b0;
                    end else begin
                        oc_cnt_reg[i] <= oc_cnt_reg[i] - 1'b1;
                    end
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Status flags, set wins over clear

    logic [7:0] status_set;
    assign status_set = {ov_trip & run, otw_now | ot_fault_now, ot_fault_now, uv_fault_now & {2{ready}}};

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            protection_status_flags <= SEFC_STATUS_RST;
            uv_warning_flags <= 2'h0;
            ocp_fault_flags <= SEFC_FLAGS_RST;
        end else if (clk_en) begin
            if (state_reg == SEFC_ST_LOAD) begin
                protection_status_flags <= SEFC_STATUS_RST;
                uv_warning_flags <= 2'h0;
                ocp_fault_flags <= SEFC_FLAGS_RST;
            end else begin
                protection_status_flags <= status_set | (flag_clear ? 8'h00 : protection_status_flags);
                uv_warning_flags <= uv_warn_now | (flag_clear ? 2'h0 : uv_warning_flags);
                ocp_fault_flags <= (oc_trip & run) | (flag_clear ? 4'h0 : ocp_fault_flags);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Standby regulator

    assign standby_level_5v = stby_reg[SEFC_STBY_LEVEL_BIT];
    always_comb begin
        unique case (stby_reg[SEFC_STBY_SRC_LSB +: 2])
            SEFC_STBY_SRC_ENABLE: standby_regulator_on = enable_sync_reg;
            SEFC_STBY_SRC_GPIO: standby_regulator_on = gpio_sync_reg[SEFC_STBY_GPIO_IDX];
            SEFC_STBY_SRC_SERIAL: standby_regulator_on = ser_standby_regulator_config[SEFC_STBY_LEVEL_BIT] | ready;
            SEFC_STBY_SRC_OFF: standby_regulator_on = 1'b0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Gate timing and dead time

    logic [15:0] dt_cnt_reg [4];
    logic [3:0] pwm_prev_reg;

    // built-in guard only without programmable dead time
    assign driver_overlap_guard_en = !prog_dt_reg;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            gate_high <= 4'h0;
            gate_low <= 4'h0;
            pwm_prev_reg <= 4'h0;
            for (int i = 0; i < 4; i++) begin
                dt_cnt_reg[i] <= SEFC_CNT_RST;
            end
        end else if (clk_en) begin
            pwm_prev_reg <= pwm_demand;
            for (int i = 0; i < 4; i++) begin
                if (!run[i]) begin
                    gate_high[i] <= 1'b0;
                    gate_low[i] <= 1'b0;
                    dt_cnt_reg[i] <= SEFC_CNT_RST;
                end else if (!prog_dt_reg) begin
                    gate_high[i] <= pwm_demand[i];
                    gate_low[i] <= !pwm_demand[i];
                    dt_cnt_reg[i] <= SEFC_CNT_RST;
                end else if (pwm_demand[i] != pwm_prev_reg[i]) begin
                    gate_high[i] <= 1'b0;
                    gate_low[i] <= 1'b0;
                    dt_cnt_reg[i] <= SEFC_CNT_RST;
                // rising gap, low off to high on
                end else if (pwm_demand[i]) begin
                    gate_low[i] <= 1'b0;
                    if (!gate_high[i]) begin
                        if (dt_cnt_reg[i] >= sefc_dead_cycles(dt_rise_reg[8*i +: 8], switch_period_cycles)) begin
                            gate_high[i] <= 1'b1;
                        end else begin
                            dt_cnt_reg[i] <= dt_cnt_reg[i] + 16'h0001;
                        end
                    end
                // falling gap, high off to low on
                end else begin
                    gate_high[i] <= 1'b0;
                    if (!gate_low[i]) begin
                        if (dt_cnt_reg[i] >= sefc_dead_cycles(dt_fall_reg[8*i +: 8], switch_period_cycles)) begin
                            gate_low[i] <= 1'b1;
                        end else begin
                            dt_cnt_reg[i] <= dt_cnt_reg[i] + 16'h0001;
                        end
                    end
                end
            end
        end
    end

endmodule : sefc_supervisor

// [inc/sefc_pkg.sv]
package sefc_pkg;

    // Chip sequencing states
    typedef enum logic [1:0] {
        SEFC_ST_OFF   = 2'b00,
        SEFC_ST_LOAD  = 2'b01,
        SEFC_ST_READY = 2'b10
    } sefc_state_t;

    // Channel enable modes, two bits per channel
    localparam logic [1:0] SEFC_MODE_OFF = 2'h0;
    localparam logic [1:0] SEFC_MODE_ALWAYS = 2'h1;
    localparam logic [1:0] SEFC_MODE_GPIO = 2'h2;
    localparam logic [1:0] SEFC_MODE_SERIAL = 2'h3;

    // Standby regulator control field positions and on/off sources
    localparam int SEFC_STBY_LEVEL_BIT = 0;
    localparam int SEFC_STBY_SRC_LSB = 1;
    localparam logic [1:0] SEFC_STBY_SRC_ENABLE = 2'h0;
    localparam logic [1:0] SEFC_STBY_SRC_GPIO = 2'h1;
    localparam logic [1:0] SEFC_STBY_SRC_SERIAL = 2'h2;
    localparam logic [1:0] SEFC_STBY_SRC_OFF = 2'h3;
    localparam logic [2:0] SEFC_STBY_GPIO_IDX = 3'h5;

    // Protection status bit positions
    localparam int SEFC_ST_UV1_BIT = 0;
    localparam int SEFC_ST_UV2_BIT = 1;
    localparam int SEFC_ST_OTP_BIT = 2;
    localparam int SEFC_ST_OVERTEMP_WARNING_BIT_BIT = 3;
    localparam int SEFC_ST_OVP_LSB = 4;

    // Auto restart configuration bit positions
    localparam int SEFC_AR_UV_BIT = 0;
    localparam int SEFC_AR_OT_BIT = 1;

    // Temperature code: 5 K per step, 200 K to 520 K
    localparam logic [6:0] SEFC_TEMP_MIN_CODE = 7'h28;
    localparam logic [6:0] SEFC_TEMP_MAX_CODE = 7'h68;
    // Warning margin in steps: 5 degrees or 10 degrees
    localparam logic [7:0] SEFC_OTW_MARGIN_NEAR = 8'h01;
    localparam logic [7:0] SEFC_OTW_MARGIN_FAR = 8'h02;

    // Dead-time step is one switching period over 256
    localparam int SEFC_DT_SHIFT = 8;

    // Over-current restart wait
    localparam longint SEFC_CLK_HZ = 10000000;
    localparam longint SEFC_OC_WAIT_MS = 200;
    localparam longint SEFC_OC_WAIT_CYCLES = (SEFC_OC_WAIT_MS * SEFC_CLK_HZ) / 1000;
    localparam int SEFC_OC_CNT_W = 24;

    // Reset values
    localparam logic [3:0] SEFC_FLAGS_RST = 4'h0;
    localparam logic [7:0] SEFC_STATUS_RST = 8'h00;
    localparam logic [15:0] SEFC_CNT_RST = 16'h0000;

endpackage : sefc_pkg

// [test/sefc_host_model.sv]
`timescale 1ns/100ps
module sefc_host_model (
    input wire logic clk,
    input wire logic resetn,
    input wire logic en_req,
    output logic chip_enable_pin
);
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) chip_enable_pin <= 1'b0;
        else chip_enable_pin <= en_req;
    end
endmodule : sefc_host_model

// [test/sefc_supervisor_sva.sv]
`timescale 1ns/100ps
module sefc_supervisor_chk (
    input wire logic clk,
    input wire logic resetn,
    input wire logic chip_enable_pin,
    input wire logic soft_reset_command,
    input wire logic [15:0] store_input_undervolt_fault_level,
    input wire logic [6:0] store_thermal_shutdown_level,
    input wire logic [7:0] primary_input_supply_code,
    input wire logic [6:0] temperature_code,
    input wire logic [3:0] oc_trip,
    input wire logic chip_ready,
    input wire logic serial_ack_allow,
    input wire logic [3:0] channel_run,
    input wire logic [7:0] protection_status_flags,
    input wire logic [3:0] ocp_fault_flags,
    input wire logic [7:0] input1_voltage_readback
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    ////////////////////////////////////////////////////////////////
    sequence s_en_held;
        (chip_enable_pin && !soft_reset_command)[*5];
    endsequence
    property p_ack; serial_ack_allow == chip_ready; endproperty
    a_ack: assert property (p_ack) else $error("ack");
    property p_rise; s_en_held |=> chip_ready; endproperty
    a_rise: assert property (p_rise) else $error("no ready");
    property p_fall; !chip_enable_pin[*3] |=> !chip_ready; endproperty
    a_fall: assert property (p_fall) else $error("ready kept");
    property p_idle; !chip_ready |-> channel_run == 4'h0; endproperty
    a_idle: assert property (p_idle) else $error("idle run");
    property p_srst; soft_reset_command |=> !chip_ready ##1 !chip_ready; endproperty
    a_srst: assert property (p_srst) else $error("srst ready");
    property p_uv;
        chip_ready && !soft_reset_command
            && primary_input_supply_code < store_input_undervolt_fault_level[7:0]
            |=> protection_status_flags[0] && channel_run == 4'h0;
    endproperty
    a_uv: assert property (p_uv) else $error("uv run");
    property p_ot;
        chip_ready && !soft_reset_command && temperature_code >= store_thermal_shutdown_level
            |=> protection_status_flags[3:2] == 2'h3 && channel_run == 4'h0 && chip_ready;
    endproperty
    a_ot: assert property (p_ot) else $error("ot run");
    property p_rb; 1'b1 |=> input1_voltage_readback == $past(primary_input_supply_code); endproperty
    a_rb: assert property (p_rb) else $error("readback");
    property p_ocp;
        chip_ready && !soft_reset_command && oc_trip[0] && channel_run[0]
            |=> (ocp_fault_flags[0] && !channel_run[0])[*8];
    endproperty
    a_ocp: assert property (p_ocp) else $error("oc hold");
endmodule : sefc_supervisor_chk
bind sefc_supervisor sefc_supervisor_chk chk (.*);

// [test/test_sefc_supervisor.sv]
`timescale 1ns/100ps
module test_sefc_supervisor;
    import sefc_pkg::*;
    logic clk, resetn, en_req, chip_enable_pin, soft_reset_command, ser_cfg_write, pdt, far, chip_ready, guard, lvl5;
    logic [5:0] gpio_pin;
    logic [3:0] serial_channel_enable, ov_trip, oc_trip, pwm_demand, channel_run, ocf, gh, gl;
    logic [7:0] mode, smode, primary_input_supply, flags, rb1;
    logic [11:0] gsel;
    logic [2:0] stby;
    logic [31:0] dts;
    logic [15:0] wl, fl, period;
    logic [6:0] tsd, trs, temp, rbt;
    logic [1:0] ar, uwf;
    int miscompares, checks, cyc, n;
    sefc_host_model host (.clk, .resetn, .en_req, .chip_enable_pin);
    sefc_supervisor #(.OC_WAIT_CYCLES(20)) dut (.clk, .resetn, .clk_en(1'b1), .chip_enable_pin, .gpio_pin,
        .soft_reset_command, .ser_cfg_write, .flag_clear(1'b0), .serial_channel_enable,
        .store_enable_mode(mode), .store_gpio_select(gsel), .store_standby_regulator_config(stby),
        .store_prog_dead_time_en(pdt), .store_rising_dead_time_setting(dts),
        .store_falling_dead_time_setting(dts), .store_input_undervolt_warning_level(wl),
        .store_input_undervolt_fault_level(fl), .store_thermal_shutdown_level(tsd),
        .store_thermal_restart_level(trs), .store_otw_far(far), .store_auto_restart(ar),
        .ser_enable_mode(smode), .ser_gpio_select(gsel), .ser_standby_regulator_config(stby),
        .ser_prog_dead_time_en(pdt), .ser_rising_dead_time_setting(dts), .ser_falling_dead_time_setting(dts),
        .ser_input_undervolt_warning_level(wl), .ser_input_undervolt_fault_level(fl),
        .ser_thermal_shutdown_level(tsd), .ser_thermal_restart_level(trs), .ser_otw_far(far),
        .ser_auto_restart(ar), .primary_input_supply_code(primary_input_supply), .secondary_input_supply_code(8'h40),
        .temperature_code(temp), .ov_trip, .oc_trip, .pwm_demand, .switch_period_cycles(period),
        .chip_ready, .serial_ack_allow(), .channel_run, .gate_high(gh), .gate_low(gl),
        .driver_overlap_guard_en(guard), .standby_regulator_on(), .standby_level_5v(lvl5),
        .protection_status_flags(flags), .uv_warning_flags(uwf), .ocp_fault_flags(ocf), .uv_warning_gpio(),
        .input1_voltage_readback(rb1), .input2_voltage_readback(), .junction_temperature_readback(rbt));
    ////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    task tick(input int k);
        repeat (k) @(posedge clk);
        #10;
    endtask : tick
    task chk(input string name, input logic [7:0] exp, input logic [7:0] seen);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk
    task summarize;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : summarize
    always @(posedge clk) begin
        cyc++;
        if (cyc > 3000) begin
            miscompares++;
            summarize();
        end
    end
    ////////////////////////////////////////////////////////////////
    task t_enable;
        en_req = 1'b1;
        tick(3);
        chk("early", 8'h0, chip_ready);
        tick(1);
        chk("ready", 8'h1, chip_ready);
        chk("run", 8'h3, channel_run);
        serial_channel_enable = 4'h8;
        tick(2);
        chk("serial", 8'hb, channel_run);
        chk("gates", 8'h1a, {gh, gl});
        chk("guard", 8'h1, guard);
        chk("level", 8'h1, lvl5);
        $display("done enable");
    endtask : t_enable
    task t_uv;
        primary_input_supply = 8'h27;
        tick(2);
        chk("uv flags", 8'h3, {flags[0], uwf[0]});
        chk("uv run", 8'h0, channel_run);
        primary_input_supply = 8'h30;
        tick(3);
        chk("uv hold", 8'h0, channel_run);
        primary_input_supply = 8'h31;
        tick(3);
        chk("uv back", 8'hb, channel_run);
        chk("readback", 8'h31, rb1);
        $display("done uv");
    endtask : t_uv
    task t_ot;
        temp = 7'h4f;
        tick(2);
        chk("ot warn", 8'h2, flags[3:2]);
        chk("temp", 8'h4f, rbt);
        temp = 7'h50;
        tick(2);
        chk("ot flags", 8'h3, flags[3:2]);
        chk("ot run", 8'h0, channel_run);
        temp = 7'h48;
        tick(3);
        chk("ot back", 8'hb, channel_run);
        $display("done ot");
    endtask : t_ot
    task t_ocp;
        oc_trip = 4'h1;
        tick(1);
        oc_trip = 4'h0;
        while (!channel_run[0] && n < 60) begin
            tick(1);
            n++;
        end
        chk("ocp flag", 8'h1, ocf[0]);
        chk("ocp wait", 8'h1, n >= 19 && n <= 23);
        $display("done ocp");
    endtask : t_ocp
    task t_srst;
        smode = 8'h00;
        ser_cfg_write = 1'b1;
        tick(1);
        ser_cfg_write = 1'b0;
        tick(2);
        chk("ser mode", 8'h8, channel_run);
        soft_reset_command = 1'b1;
        tick(1);
        soft_reset_command = 1'b0;
        chk("srst drop", 8'h0, chip_ready);
        tick(3);
        chk("srst up", 8'h1, chip_ready);
        chk("reload", 8'hb, channel_run);
        chk("flags", 8'h0, flags);
        ov_trip = 4'h1;
        tick(2);
        chk("ovp", 8'h1a, {flags[4], channel_run});
        en_req = 1'b0;
        tick(4);
        chk("disabled", 8'h0, chip_ready);
        $display("done reset");
    endtask : t_srst
    initial begin
        resetn = 1'b0; en_req = 1'b0; soft_reset_command = 1'b0; ser_cfg_write = 1'b0;
        gpio_pin = 6'h02; serial_channel_enable = 4'h0; ov_trip = 4'h0; oc_trip = 4'h0;
        pwm_demand = 4'h5; mode = 8'he9; smode = 8'he9; gsel = 12'h088; stby = 3'h1; pdt = 1'b0;
        far = 1'b0; dts = 32'h10101010; wl = 16'h3030; fl = 16'h2828; period = 16'h0040;
        tsd = 7'h50; trs = 7'h48; ar = 2'h3; primary_input_supply = 8'h40; temp = 7'h40;
        tick(20);
        resetn = 1'b1;
        tick(2);
        t_enable();
        t_uv();
        t_ot();
        t_ocp();
        t_srst();
        summarize();
    end
endmodule : test_sefc_supervisor
